// ---- hw/asc_pkg.sv ----
// Purpose: Constants and types for the angle sensor serial config port
// Assumes: 10 MHz core clock, 16-bit mode 3 frames
// Notes: Frame packing is local and may change once fixed
package asc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CLK_NS = 100;
  localparam int REFRESH_KHZ = 500;
  localparam int REFRESH_CYC = 1000000 / (REFRESH_KHZ * CLK_NS);
  localparam int LATENCY_NS = 3000;
  localparam int LATENCY_CYC = LATENCY_NS / CLK_NS;
  localparam int PUBLISH_CYC = LATENCY_CYC - REFRESH_CYC;
  localparam logic [3:0] ADDR_BIAS = 4'h3;
  localparam logic [3:0] ADDR_ZERO = 4'h4;
  localparam logic [3:0] ADDR_TRIM = 4'h5;
  localparam logic [3:0] ADDR_FLASH = 4'h9;
  localparam int TRIM_X_BIT = 4;
  localparam int TRIM_Y_BIT = 5;
  localparam int FLASH_LO_BIT = 3;
  localparam logic [7:0] TRIM_MASK = 8'h30;
  localparam logic [7:0] FLASH_MASK = 8'h38;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] ZERO_LOW_RESET = 4'h0;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [4:0] CNT_FRAME = 5'h10;

  // Command word: write flag, spare, register address, write data
  typedef struct packed {
    logic wr;
    logic [2:0] spare;
    logic [3:0] addr;
    logic [7:0] data;
  } asc_cmd_type;

  // Reply word: current angle, then readback of previous frame's address
  typedef struct packed {
    logic [7:0] angle;
    logic [7:0] rdata;
  } asc_reply_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } asc_pins_type;
endpackage

// ---- hw/asc_sync.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module asc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_q[i] <= INIT[i];
          q[i] <= INIT[i];
        end else begin
          meta_q[i] <= d[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

// ---- hw/asc_top.sv ----
// Purpose: Serial slave port, settings bank and angle publishing
// Assumes: Serial pins sampled by clk; angle_raw is on the clk domain
// Notes: Serial clock must be well below clk/4 for edge detection
`timescale 1ns/1ps
module asc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  input wire logic [7:0] angle_raw,
  output logic [7:0] angle_o,
  output logic [7:0] bias_x_o,
  output logic [7:0] bias_y_o,
  output logic [11:0] zero_pos_o,
  output logic [2:0] flash_commit_o,
  output logic [7:0] flash_data_o
);
  asc_pkg::asc_pins_type pins_s;
  asc_pkg::asc_pins_type pins_raw;
  asc_pkg::asc_cmd_type cmd;
  asc_pkg::asc_reply_type reply;
  logic sclk_d_q, cs_n_d_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, exec;
  logic [4:0] cnt_q;
  logic [15:0] rx_q, tx_q;
  logic [7:0] rdata_q;
  logic [7:0] bias_trim_amount_q, zero_position_high_q;
  logic [7:0] axis_trim_enables_q, flash_commit_control_q;
  logic [3:0] zero_low_q;
  logic [7:0] sample_q;
  logic [5:0] ref_cnt_q, pub_cnt_q;
  logic tick, pub_pending_q, pub;

  function automatic logic [7:0] rd_mux(input logic [3:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] z,
                                        input logic [7:0] t,
                                        input logic [7:0] f);
    unique case (a)
      asc_pkg::ADDR_BIAS: rd_mux = b;
      asc_pkg::ADDR_ZERO: rd_mux = z;
      asc_pkg::ADDR_TRIM: rd_mux = t;
      asc_pkg::ADDR_FLASH: rd_mux = f;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Pins are only inputs: no drive path exists for clock or select
  assign pins_raw = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

  asc_sync #(.W(3), .INIT(3'h6)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pins_raw),
    .q(pins_s)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_q <= 1'b1;
      cs_n_d_q <= 1'b1;
    end else begin
      sclk_d_q <= pins_s.sclk;
      cs_n_d_q <= pins_s.cs_n;
    end
  end

  // Mode 3: sample on rise, shift out on fall, select active low
  assign sclk_rise = pins_s.sclk & ~sclk_d_q & ~pins_s.cs_n;
  assign sclk_fall = ~pins_s.sclk & sclk_d_q & ~pins_s.cs_n;
  assign cs_fall = ~pins_s.cs_n & cs_n_d_q;
  assign cs_rise = pins_s.cs_n & ~cs_n_d_q;
  // Only a frame of exactly 16 bits acts; short or long ones are dropped
  assign exec = cs_rise && (cnt_q == asc_pkg::CNT_FRAME);
  assign cmd = asc_pkg::asc_cmd_type'(rx_q);
  assign reply = '{angle: angle_o, rdata: rdata_q};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 5'h00;
      rx_q <= 16'h0000;
    end else if (cs_fall) begin
      cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      rx_q <= {rx_q[14:0], pins_s.mosi};
      if (cnt_q != asc_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // MSB stands from select fall; the first falling edge keeps it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_q <= 16'h0000;
    end else if (cs_fall) begin
      tx_q <= reply;
    end else if (sclk_fall && cnt_q != 5'h00) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign miso_o = tx_q[15];
  // Driven only while selected, so a shared data line stays free
  assign miso_oe = ~pins_s.cs_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bias_trim_amount_q <= asc_pkg::REG_RESET;
      zero_position_high_q <= asc_pkg::REG_RESET;
      axis_trim_enables_q <= asc_pkg::REG_RESET;
      flash_commit_control_q <= asc_pkg::REG_RESET;
    end else if (exec && cmd.wr) begin
      unique case (cmd.addr)
        asc_pkg::ADDR_BIAS: bias_trim_amount_q <= cmd.data;
        asc_pkg::ADDR_ZERO: zero_position_high_q <= cmd.data;
        asc_pkg::ADDR_TRIM:
          axis_trim_enables_q <= cmd.data & asc_pkg::TRIM_MASK;
        asc_pkg::ADDR_FLASH:
          flash_commit_control_q <= cmd.data & asc_pkg::FLASH_MASK;
        default: ;
      endcase
    end
  end

  // No write path yet for the low zero bits; held at reset value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zero_low_q <= asc_pkg::ZERO_LOW_RESET;
    end else begin
      zero_low_q <= zero_low_q;
    end
  end

  assign zero_pos_o = {zero_position_high_q, zero_low_q};

  // Readback for the next frame; reads the value before this frame's write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (exec) begin
      rdata_q <= rd_mux(cmd.addr, bias_trim_amount_q, zero_position_high_q,
                        axis_trim_enables_q, flash_commit_control_q);
    end
  end

  // Single-bit commit pulses carry that register's contents to the OTP writer; multi-bit ones send 00
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flash_commit_o <= 3'h0;
      flash_data_o <= 8'h00;
    end else begin
      flash_commit_o <= 3'h0;
      if (exec && cmd.wr && cmd.addr == asc_pkg::ADDR_FLASH) begin
        flash_commit_o <= cmd.data[asc_pkg::FLASH_LO_BIT +: 3];
        unique case (cmd.data[asc_pkg::FLASH_LO_BIT +: 3])
          3'h1: flash_data_o <= bias_trim_amount_q;
          3'h2: flash_data_o <= zero_position_high_q;
          3'h4: flash_data_o <= axis_trim_enables_q;
          default: flash_data_o <= 8'h00;
        endcase
      end
    end
  end

  // Both enables give equal reduction, so no side-shaft correction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bias_x_o <= 8'h00;
      bias_y_o <= 8'h00;
    end else begin
      bias_x_o <= axis_trim_enables_q[asc_pkg::TRIM_X_BIT] ?
                  bias_trim_amount_q : 8'h00;
      bias_y_o <= axis_trim_enables_q[asc_pkg::TRIM_Y_BIT] ?
                  bias_trim_amount_q : 8'h00;
    end
  end

  // Sample cadence and publish delay
  assign tick = ref_cnt_q == 6'(asc_pkg::REFRESH_CYC - 1);
  assign pub = pub_pending_q && pub_cnt_q == 6'(asc_pkg::PUBLISH_CYC - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_q <= 6'h00;
      sample_q <= 8'h00;
    end else begin
      ref_cnt_q <= tick ? 6'h00 : ref_cnt_q + 6'h01;
      if (tick) begin
        sample_q <= angle_raw;
      end
    end
  end

  // Publish after the remaining latency; next sample arrives later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pub_pending_q <= 1'b0;
      pub_cnt_q <= 6'h00;
      angle_o <= 8'h00;
    end else begin
      if (tick) begin
        pub_pending_q <= 1'b1;
        pub_cnt_q <= 6'h00;
      end else if (pub) begin
        pub_pending_q <= 1'b0;
        angle_o <= sample_q - zero_position_high_q;
      end else if (pub_pending_q) begin
        pub_cnt_q <= pub_cnt_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_wr(logic [3:0] a);
    exec && cmd.wr && cmd.addr == a;
  endsequence

  a_miso_idle_off: assert property (
    pins_s.cs_n |-> !miso_oe)
    else $error("MISO driven while deselected");
  a_frame_msb: assert property (
    cs_fall |=> miso_o == $past(reply[15]))
    else $error("MSB not first on MISO");
  a_frame_len: assert property (
    cs_rise && cnt_q != asc_pkg::CNT_FRAME |=> $stable(rdata_q))
    else $error("Non 16-bit frame acted");
  a_bias_write: assert property (
    s_wr(asc_pkg::ADDR_BIAS) |=> bias_trim_amount_q == $past(cmd.data))
    else $error("Bias amount not written");
  a_zero_write: assert property (
    s_wr(asc_pkg::ADDR_ZERO) |=> zero_pos_o[11:4] == $past(cmd.data))
    else $error("Zero high not written");
  a_trim_zero_bits: assert property (
    (axis_trim_enables_q & ~asc_pkg::TRIM_MASK) == 8'h00)
    else $error("Reserved trim bits set");
  a_y_trim: assert property (
    s_wr(asc_pkg::ADDR_TRIM) ##1 1'b1 |=>
      bias_y_o == ($past(cmd.data[5], 2) ? bias_trim_amount_q : 8'h00))
    else $error("Y trim wrong");
  a_both_equal: assert property (
    axis_trim_enables_q[5:4] == 2'h3 |=> bias_x_o == bias_y_o)
    else $error("Axes trimmed unequally");
  a_flash_pulse: assert property (
    s_wr(asc_pkg::ADDR_FLASH) |=> flash_commit_o == $past(cmd.data[5:3])
      ##1 flash_commit_o == 3'h0)
    else $error("Commit pulse wrong");
  a_refresh_rate: assert property (
    tick |=> !tick [*8] ##12 tick)
    else $error("Refresh not 20 cycles");
  a_latency: assert property (
    tick |-> ##10 pub)
    else $error("Publish not 10 cycles after sample");
  a_zero_low: assert property (
    zero_pos_o[3:0] == asc_pkg::ZERO_LOW_RESET)
    else $error("Low zero bits moved");
endmodule

// ---- tb/asc_spi_master.sv ----
// Purpose: Mode 3 serial master model that drives the sensor port
// Assumes: Half clock period of 4 core cycles, 800 ns per bit
// Notes: Bit count can be cut short to send a broken frame
`timescale 1ns/1ps
module asc_spi_master (
  input wire logic clk,
  input wire logic miso_o,
  input wire logic miso_oe,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Only the master moves clock and select; both idle high
  task automatic xfer(input logic [15:0] tx, input int nb,
                      output logic [15:0] rx);
    rx = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    wt(4);
    for (int i = 15; i > 15 - nb; i--) begin // MSB first
      sclk <= 1'b0;
      mosi <= tx[i];
      wt(4);
      // Taken as the clock rises; undriven line reads unknown
      rx[i] = miso_oe ? miso_o : 1'bx;
      sclk <= 1'b1;
      wt(4);
    end
    cs_n <= 1'b1;
    mosi <= ~mosi;
    wt(8);
  endtask
endmodule

// ---- tb/asc_top_tb.sv ----
// Purpose: Self-checking bench for the sensor serial settings port
// Assumes: Command {wr,spare,addr,data}, reply {angle,readback}
// Notes: Readback shows the address of the frame before
`timescale 1ns/1ps
module asc_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] angle_raw = 8'h80;
  logic sclk, cs_n, mosi, miso_o, miso_oe;
  logic [7:0] angle_o, bias_x_o, bias_y_o, flash_data_o;
  logic [11:0] zero_pos_o;
  logic [2:0] flash_commit_o;
  logic [2:0] commit_seen = 3'h0;
  logic [15:0] rx;
  int failures = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (flash_commit_o !== 3'h0) begin
      commit_seen <= flash_commit_o;
    end
  end
  asc_top u_asc_top (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
    .angle_raw(angle_raw), .angle_o(angle_o), .bias_x_o(bias_x_o),
    .bias_y_o(bias_y_o), .zero_pos_o(zero_pos_o),
    .flash_commit_o(flash_commit_o), .flash_data_o(flash_data_o));
  asc_spi_master u_asc_spi_master (.clk(clk), .miso_o(miso_o),
    .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic sx(input logic [15:0] tx);
    u_asc_spi_master.xfer(tx, 16, rx);
  endtask
  task automatic t_reset();
    chk({angle_o, bias_x_o}, 16'h0000, "reset angle bias");
    chk({4'h0, zero_pos_o}, 16'h0000, "reset zero");
    chk({15'h0, miso_oe}, 16'h0000, "idle miso enable");
    $display("test reset done");
  endtask
  task automatic t_regs();
    sx(16'h83ab);
    sx(16'h845a);
    sx(16'h0300);
    chk({8'h00, rx[7:0]}, 16'h0000, "old zero");
    sx(16'h0400);
    chk({8'h00, rx[7:0]}, 16'h00ab, "bias readback");
    sx(16'h0000);
    chk({8'h00, rx[7:0]}, 16'h005a, "zero readback");
    chk({8'h00, rx[15:8]}, 16'h0026, "reply angle");
    chk({4'h0, zero_pos_o}, 16'h05a0, "zero position");
    $display("test regs done");
  endtask
  task automatic t_axes();
    sx(16'h8510);
    u_asc_spi_master.wt(6);
    chk({bias_x_o, bias_y_o}, 16'hab00, "x trim only");
    sx(16'h8520);
    u_asc_spi_master.wt(6);
    chk({bias_x_o, bias_y_o}, 16'h00ab, "y trim only");
    sx(16'h85ff);
    u_asc_spi_master.wt(6);
    chk({bias_x_o, bias_y_o}, 16'habab, "both trims");
    sx(16'h0500);
    chk({8'h00, rx[7:0]}, 16'h0020, "old trim");
    sx(16'h0000);
    chk({8'h00, rx[7:0]}, 16'h0030, "trim masked");
    sx(16'h0000);
    chk({8'h00, rx[7:0]}, 16'h0000, "unmapped read");
    $display("test axes done");
  endtask
  task automatic t_flash();
    logic [7:0] exp [3] = '{8'hab, 8'h5a, 8'h30};
    for (int k = 0; k < 3; k++) begin
      sx({8'h89, 8'h08 << k});
      u_asc_spi_master.wt(6);
      chk({13'h0, commit_seen}, 16'h1 << k, "commit bit");
      chk({8'h00, flash_data_o}, {8'h00, exp[k]}, "commit data");
    end
    $display("test flash done");
  endtask
  task automatic t_short();
    u_asc_spi_master.xfer(16'h8311, 15, rx);
    sx(16'h0300);
    sx(16'h0000);
    chk({8'h00, rx[7:0]}, 16'h00ab, "short frame ignored");
    $display("test short done");
  endtask
  task automatic t_angle();
    int n;
    n = 0;
    @(posedge clk) angle_raw <= 8'h10;
    while (angle_o !== 8'hb6 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n[15:0] >= 16'd10 && n[15:0] <= 16'd31, 16'h1,
        "angle latency");
    $display("test angle done");
  endtask
  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #3ms;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_axes();
    t_flash();
    t_short();
    t_angle();
    give_verdict();
  end
endmodule
